// ### rtl/ularg_pkg.sv
// shared constants and types for the ulpi register access block
package ularg_pkg;
   // ---------------------------------------------------------------
   // command byte layout
   // ---------------------------------------------------------------
   localparam int unsigned ULARG_CLASS_HI = 7;
   localparam int unsigned ULARG_CLASS_LO = 6;
   localparam logic [1:0] ULARG_CLASS_IDLE = 2'h0;
   localparam logic [1:0] ULARG_CLASS_TX = 2'h1;
   localparam logic [1:0] ULARG_CLASS_WR = 2'h2;
   localparam logic [1:0] ULARG_CLASS_RD = 2'h3;
   localparam logic [5:0] ULARG_EXT_CODE = 6'h2f;
   localparam logic [5:0] ULARG_NOPID_CODE = 6'h00;
   localparam logic [7:0] ULARG_IDLE_BYTE = 8'h00;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] ULARG_BYTE_RST = 8'h00;
   localparam logic ULARG_BIT_RST = 1'b0;
   // ---------------------------------------------------------------
   // protocol states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD, ST_NXTWAIT, ST_EXTADR, ST_WDATA, ST_WSTOP,
      ST_COMMIT, ST_RDRIVE, ST_RDONE, ST_TURNBACK, ST_TXSKIP
   } ularg_state_t;
endpackage

// ### rtl/ularg_top.sv
// ulpi phy-side command decode and register array access
`timescale 1ns/1ps
module ularg_top
   import ularg_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_NRST,
   input wire logic I_ULPI_CLK,
   input wire logic [7:0] I_DATA,
   input wire logic I_STP,
   input wire logic I_MODE_HOLD,
   output logic [7:0] O_DATA,
   output logic O_DATA_OE,
   output logic O_DIR,
   output logic O_NXT,
   output logic O_TX_VALID,
   output logic O_TX_NOPID,
   output logic [3:0] O_TX_PID
);
   // ---------------------------------------------------------------
   // synchronisers and edge detect
   // ---------------------------------------------------------------
   logic clk_s1_r, clk_s2_r, clk_s3_r;
   logic [7:0] dat_s1_r, dat_s2_r;
   logic stp_s1_r, stp_s2_r;
   logic rise, fall;
   logic [7:0] bus_r;
   logic stp_smp_r;
   ularg_state_t state_r;
   logic [7:0] cmd_r, addr_r, wdata_r;
   logic dir_r, nxt_r, oe_r;
   logic [7:0] dout_r;
   logic tx_valid_r, tx_nopid_r;
   logic [3:0] tx_pid_r;
   logic [7:0] regs_mem [0:255];
   logic mem_we;
   logic is_ext, is_rd;

   // two flops on every pin from the link side, a third on the interface clock for edge detect
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         clk_s1_r <= ULARG_BIT_RST;
         clk_s2_r <= ULARG_BIT_RST;
         clk_s3_r <= ULARG_BIT_RST;
         dat_s1_r <= ULARG_BYTE_RST;
         dat_s2_r <= ULARG_BYTE_RST;
         stp_s1_r <= ULARG_BIT_RST;
         stp_s2_r <= ULARG_BIT_RST;
      end else begin
         clk_s1_r <= I_ULPI_CLK;
         clk_s2_r <= clk_s1_r;
         clk_s3_r <= clk_s2_r;
         dat_s1_r <= I_DATA;
         dat_s2_r <= dat_s1_r;
         stp_s1_r <= I_STP;
         stp_s2_r <= stp_s1_r;
      end
   end

   // edge pulses of the interface clock
   assign rise = clk_s2_r & ~clk_s3_r;
   assign fall = ~clk_s2_r & clk_s3_r;

   // sample link signals mid-cycle, where they are stable
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         bus_r <= ULARG_BYTE_RST;
         stp_smp_r <= ULARG_BIT_RST;
      end else if (fall) begin
         bus_r <= dat_s2_r;
         stp_smp_r <= stp_s2_r;
      end
   end

   // ---------------------------------------------------------------
   // command decode helpers
   // ---------------------------------------------------------------
   assign is_ext = (cmd_r[5:0] == ULARG_EXT_CODE);
   assign is_rd = (cmd_r[ULARG_CLASS_HI:ULARG_CLASS_LO] == ULARG_CLASS_RD);
   assign mem_we = rise && (state_r == ST_COMMIT) && !stp_smp_r;

   // ---------------------------------------------------------------
   // protocol state machine
   // ---------------------------------------------------------------
   // all bus outputs move only on interface clock rising edges
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state_r <= ST_IDLE;
         cmd_r <= ULARG_BYTE_RST;
         addr_r <= ULARG_BYTE_RST;
         wdata_r <= ULARG_BYTE_RST;
         dir_r <= ULARG_BIT_RST;
         nxt_r <= ULARG_BIT_RST;
         oe_r <= ULARG_BIT_RST;
         dout_r <= ULARG_BYTE_RST;
      end else if (rise) begin
         unique case (state_r)
            ST_IDLE: begin
               // idle byte and hold modes start nothing
               if (!I_MODE_HOLD && bus_r != ULARG_IDLE_BYTE) begin
                  cmd_r <= bus_r;
                  addr_r <= {2'h0, bus_r[5:0]};
                  if (bus_r[ULARG_CLASS_HI:ULARG_CLASS_LO] == ULARG_CLASS_TX) begin
                     state_r <= ST_TXSKIP;
                  end else begin
                     state_r <= ST_CMD;
                  end
               end
            end
            ST_CMD: begin
               nxt_r <= 1'b1;
               state_r <= ST_NXTWAIT;
            end
            ST_NXTWAIT: begin
               if (is_ext) begin
                  state_r <= ST_EXTADR;
               end else if (is_rd) begin
                  dir_r <= 1'b1;
                  nxt_r <= 1'b0;
                  state_r <= ST_RDRIVE;
               end else begin
                  state_r <= ST_WDATA;
               end
            end
            ST_EXTADR: begin
               addr_r <= bus_r;
               if (is_rd) begin
                  dir_r <= 1'b1;
                  nxt_r <= 1'b0;
                  state_r <= ST_RDRIVE;
               end else begin
                  state_r <= ST_WDATA;
               end
            end
            ST_WDATA: begin
               wdata_r <= bus_r;
               if (is_ext) begin
                  nxt_r <= 1'b0;
               end
               state_r <= ST_WSTOP;
            end
            ST_WSTOP: begin
               // link marks the end with stop
               if (stp_smp_r) begin
                  nxt_r <= 1'b0;
                  state_r <= ST_COMMIT;
               end
            end
            ST_COMMIT: begin
               if (!stp_smp_r) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_RDRIVE: begin
               // turn-around passed, drive register value
               oe_r <= 1'b1;
               dout_r <= regs_mem[addr_r];
               state_r <= ST_RDONE;
            end
            ST_RDONE: begin
               dir_r <= 1'b0;
               oe_r <= 1'b0;
               dout_r <= ULARG_BYTE_RST;
               state_r <= ST_TURNBACK;
            end
            ST_TURNBACK: begin
               state_r <= ST_IDLE;
            end
            ST_TXSKIP: begin
               // transmit payload is handled elsewhere; wait for stop
               if (stp_smp_r) begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // transmit command decode strobe
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         tx_valid_r <= ULARG_BIT_RST;
         tx_nopid_r <= ULARG_BIT_RST;
         tx_pid_r <= 4'h0;
      end else begin
         tx_valid_r <= rise && (state_r == ST_IDLE) && !I_MODE_HOLD
            && (bus_r[ULARG_CLASS_HI:ULARG_CLASS_LO] == ULARG_CLASS_TX);
         // only a taken transmit command updates the fields, idle bytes leave them
         if (rise && state_r == ST_IDLE && !I_MODE_HOLD
            && bus_r[ULARG_CLASS_HI:ULARG_CLASS_LO] == ULARG_CLASS_TX) begin
            tx_nopid_r <= (bus_r[5:0] == ULARG_NOPID_CODE);
            tx_pid_r <= bus_r[3:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // register array, no reset so contents survive every mode
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (mem_we) begin
         regs_mem[addr_r] <= wdata_r;
      end
   end

   // outputs straight from flops
   assign O_DATA = dout_r;
   assign O_DATA_OE = oe_r;
   assign O_DIR = dir_r;
   assign O_NXT = nxt_r;
   assign O_TX_VALID = tx_valid_r;
   assign O_TX_NOPID = tx_nopid_r;
   assign O_TX_PID = tx_pid_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);

   a_write_dir_low: assert property ((state_r == ST_WDATA || state_r == ST_WSTOP
      || state_r == ST_COMMIT) |-> !dir_r) else $error("dir high in write");
   a_nxt_raise_cmd: assert property ($rose(nxt_r) |-> $past(state_r) == ST_CMD)
      else $error("nxt rose outside command");
   a_read_turn_nxt: assert property ($rose(dir_r) |-> $fell(nxt_r))
      else $error("nxt not dropped with dir");
   a_turn_no_drive: assert property ($rose(dir_r) |-> !oe_r ##1 !oe_r)
      else $error("drive during turn-around");
   a_read_release: assert property ($fell(oe_r) |-> $fell(dir_r))
      else $error("dir not dropped after read");
   a_drive_one: assert property ($rose(oe_r) |-> oe_r ##[6:12] $fell(oe_r))
      else $error("read data not one interface cycle");
   a_commit_stp: assert property ($rose(state_r == ST_COMMIT) |-> $past(stp_smp_r))
      else $error("commit without stop");
   a_ext_addr_take: assert property ((rise && state_r == ST_EXTADR)
      |=> addr_r == $past(bus_r)) else $error("extended address lost");
   a_imm_addr_take: assert property ((rise && state_r == ST_IDLE && !I_MODE_HOLD
      && bus_r[ULARG_CLASS_HI]) |=> addr_r == {2'h0, $past(bus_r[5:0])})
      else $error("immediate address wrong");
   a_tx_pid_field: assert property (tx_valid_r |-> tx_pid_r == cmd_r[3:0])
      else $error("pid field wrong");

   c_write_commit: cover property (mem_we);
   c_read_drive: cover property ($rose(oe_r));
   c_ext_read: cover property (rise && state_r == ST_EXTADR && is_rd);
   c_tx_cmd: cover property (tx_valid_r && !tx_nopid_r);
endmodule

// ### verification/ularg_link.sv
// link-side partner model for the ulpi bus
`timescale 1ns/1ps
module ularg_link
   import ularg_pkg::*;
(
   input wire logic i_clk,
   input wire logic [7:0] i_bus,
   input wire logic i_dir,
   input wire logic i_nxt,
   output logic [7:0] o_data,
   output logic o_stp
);
   logic [7:0] last = 8'h00;
   // idle bus and stop low until a transfer starts
   initial begin
      o_data = 8'h00;
      o_stp = 1'b0;
   end
   // step to just after the next bus clock edge
   task automatic tick();
      @(posedge i_clk);
      #2;
   endtask
   task automatic put(input logic [7:0] v);
      o_data = v;
      last = v;
   endtask
   // one-cycle stop with idle on the bus
   task automatic stop1();
      put(ULARG_IDLE_BYTE);
      o_stp = 1'b1;
      tick();
      o_stp = 1'b0;
   endtask
   // one access; nw is the edge count to next-byte, 20 means a timeout
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] adr,
      input logic [7:0] wd, output logic [7:0] rd, output int nw);
      int n;
      rd = 8'h00;
      nw = 0;
      tick(); // start just after a bus clock edge
      for (n = 0; n < 20 && i_dir; n++) tick();
      put(cmd);
      if (cmd[7:6] == ULARG_CLASS_TX) begin
         tick();
         stop1();
      end else begin
         for (nw = 1; nw < 20; nw++) begin
            tick();
            if (i_nxt) break;
         end
         if (cmd[5:0] == ULARG_EXT_CODE) begin
            put(adr);
            tick();
         end
         if (cmd[7:6] == ULARG_CLASS_WR) begin
            put(wd);
            tick();
            stop1();
         end else begin
            put(ULARG_IDLE_BYTE);
            for (n = 0; n < 20 && !i_dir; n++) tick();
            if (n == 20) nw = 20;
            o_data = ~last; // released: no stale byte
            tick();
            rd = i_bus;
            for (n = 0; n < 20 && i_dir; n++) tick();
            if (n == 20) nw = 20;
            put(ULARG_IDLE_BYTE);
         end
      end
      tick();
      tick();
   endtask
endmodule

// ### verification/test_ulpi_register_access.sv
// self-checking bench for the ulpi register access block
`timescale 1ns/1ps
module test_ulpi_register_access
   import ularg_pkg::*;
;
   logic clk = 1'b0;
   logic uclk = 1'b0;
   logic nrst = 1'b0;
   logic hold = 1'b0;
   logic in_wr = 1'b0;
   logic stp, oe, dir, nxt, txv, nopid;
   logic np_seen = 1'b0;
   logic [7:0] ld, pd, bus;
   logic [3:0] pid;
   logic [3:0] pid_seen = 4'h0;
   int bad_count = 0;
   int n_tests = 0;
   int tx_n = 0;
   assign bus = oe ? pd : ld; // resolved data wire
   ularg_top i_ularg_top (.I_CLK(clk), .I_NRST(nrst), .I_ULPI_CLK(uclk), .I_DATA(bus),
      .I_STP(stp), .I_MODE_HOLD(hold), .O_DATA(pd), .O_DATA_OE(oe), .O_DIR(dir),
      .O_NXT(nxt), .O_TX_VALID(txv), .O_TX_NOPID(nopid), .O_TX_PID(pid));
   ularg_link i_ularg_link (.i_clk(uclk), .i_bus(bus), .i_dir(dir), .i_nxt(nxt),
      .o_data(ld), .o_stp(stp));
   // system clock and unrelated bus clock
   initial forever #20 clk = ~clk;
   initial begin
      #7;
      forever #160 uclk = ~uclk;
   end
   // capture transmit decode and watch direction during writes
   always @(posedge clk) begin
      if (txv === 1'b1) begin
         pid_seen <= pid;
         np_seen <= nopid;
         tx_n <= tx_n + 1;
      end
      if (in_wr && dir !== 1'b0) begin
         $display("[FAIL] dir in write exp 0 got %b", dir);
         bad_count++;
      end
   end
   task automatic stop_test();
      if (bad_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %s exp %h got %h", what, exp, got);
         bad_count++;
      end
   endtask
   // one link access, checked for handshake timing and read data
   task automatic acc(input logic [7:0] cmd, input logic [7:0] adr,
      input logic [7:0] wd, input logic [7:0] exp);
      logic [7:0] rd;
      int nw;
      in_wr = (cmd[7:6] == ULARG_CLASS_WR);
      i_ularg_link.xfer(cmd, adr, wd, rd, nw);
      in_wr = 1'b0;
      if (cmd[7:6] != ULARG_CLASS_TX) chk("nxt delay", 8'h03, 8'(nw));
      if (nw >= 20) stop_test();
      if (cmd[7:6] == ULARG_CLASS_RD) chk("read data", exp, rd);
      chk("oe dir nxt", 8'h00, {5'h00, oe, dir, nxt});
   endtask
   // immediate writes at edge addresses, then read back
   task automatic t_imm();
      logic [7:0] v [3] = '{8'ha5, 8'h0f, 8'h5a};
      logic [5:0] a [3] = '{6'h00, 6'h2e, 6'h3f};
      for (int i = 0; i < 3; i++) acc({ULARG_CLASS_WR, a[i]}, 8'h00, v[i], 8'h00);
      for (int i = 0; i < 3; i++) acc({ULARG_CLASS_RD, a[i]}, 8'h00, 8'h00, v[i]);
   endtask
   // extended accesses, cross-checked with immediate ones
   task automatic t_ext();
      acc(8'haf, 8'hff, 8'h3c, 8'h00);
      acc(8'haf, 8'h2f, 8'hc3, 8'h00);
      acc(8'haf, 8'h05, 8'h96, 8'h00);
      acc(8'hef, 8'hff, 8'h00, 8'h3c);
      acc(8'hef, 8'h2f, 8'h00, 8'hc3);
      acc(8'hc5, 8'h00, 8'h00, 8'h96);
      acc(8'hef, 8'h2e, 8'h00, 8'h0f);
   endtask
   // contents survive a hold period
   task automatic t_hold();
      i_ularg_link.tick();
      hold = 1'b1;
      i_ularg_link.put(8'h81); // command offered while held
      repeat (3) i_ularg_link.tick();
      chk("held nxt", 8'h00, {7'h00, nxt});
      i_ularg_link.put(ULARG_IDLE_BYTE);
      repeat (2) i_ularg_link.tick();
      hold = 1'b0;
      acc(8'hc0, 8'h00, 8'h00, 8'ha5);
      acc(8'hef, 8'hff, 8'h00, 8'h3c);
   endtask
   // transmit commands with and without pid
   task automatic t_tx();
      acc(8'h40, 8'h00, 8'h00, 8'h00);
      chk("tx nopid", 8'h01, {7'h00, np_seen});
      acc(8'h4a, 8'h00, 8'h00, 8'h00);
      chk("tx pid", 8'h0a, {4'h0, pid_seen});
      chk("tx nopid", 8'h00, {7'h00, np_seen});
      chk("tx count", 8'h02, 8'(tx_n));
   endtask
   // reset, then the scenarios in turn
   initial begin
      repeat (2) @(posedge clk);
      #2;
      nrst = 1'b1;
      repeat (6) @(posedge clk);
      chk("reset outs", 8'h00, {3'h0, oe, dir, nxt, txv, nopid});
      chk("reset data", 8'h00, pd);
      chk("reset pid", 8'h00, {4'h0, pid});
      t_imm();
      t_ext();
      t_hold();
      t_tx();
      stop_test();
   end
endmodule
